// file: verilog/adc_port_pkg.sv
`default_nettype none
package adc_port_pkg;
    // device release window after the last serial edge, oscillator periods
    localparam int unsigned RELEASE_MIN_OSC = 6;
    localparam int unsigned RELEASE_MAX_OSC = 10;
    // release point, counted from the synchronised edge: the pin
    // synchroniser and edge detect add about 3 periods, so the pin sees
    // the release 8 to 9 periods after the last edge, inside the window
    localparam logic [3:0] RELEASE_AT_OSC = 4'h5;
    // output data register invalid span during update, oscillator periods
    localparam logic [2:0] UPDATE_INVALID_OSC = 3'h4;
    localparam int unsigned WORD_BITS = 24;
    localparam int unsigned GPIO_BITS = 8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_HOLD = 2'b10
    } port_state_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
    } serial_in_t;

    typedef struct packed {
        logic dout;
        logic dout_oe;
        logic conversion_ready_n;
    } serial_out_t;
endpackage
`default_nettype wire

// file: verilog/adc_serial_port.sv
// Behaviour
// - power_down_n low halts all digital logic of the device; here its synchroniser runs, gpio data passes through and gpio_pin_oe is held low.
// - chip select low enables the port; clock and data ignored when high.
// - conversion_ready_n is active low, falls when new data is available.
// - serial data output goes high impedance at once when chip select rises.
// - output released 6 to 10 oscillator periods after last serial edge.
// - output data register invalid for 4 periods while being updated.
// - analog input n shares its pin with general-purpose data bit n.
// - ready falling edge marks start of a new conversion.
`timescale 1ns/10ps
`default_nettype none
module adc_serial_port (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic power_down_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    output logic conversion_ready_n,
    input wire logic [23:0] conv_data,
    input wire logic conv_valid,
    input wire logic [7:0] gpio_in,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_dir,
    output logic [7:0] gpio_pin_out,
    output logic [7:0] gpio_pin_oe,
    output logic [7:0] gpio_pin_in,
    output logic [7:0] rx_byte,
    output logic rx_byte_valid
);
    typedef struct packed {
        adc_port_pkg::serial_in_t s1;
        adc_port_pkg::serial_in_t s2;
        logic sclk_prev;
        logic pdn1;
        logic pdn2;
        adc_port_pkg::port_state_t st;
        logic [23:0] out_reg;
        logic [23:0] shift;
        logic [4:0] bit_cnt;
        logic [7:0] rx_sh;
        logic [2:0] rx_cnt;
        logic [7:0] rx_byte;
        logic rx_valid;
        logic [3:0] idle_cnt;
        logic [2:0] upd_cnt;
        logic rdy_n;
        logic dout;
        logic oe;
    } state_t;

    state_t q, d;
    logic rise, fall, active;

    // active-low synchronised chip select gates every serial action
    function automatic logic port_open(input adc_port_pkg::serial_in_t s);
        port_open = !s.cs_n;
    endfunction

    always_comb begin
        d = q;
        // two flops on each serial pin and power_down_n; raw cs_n also feeds dout_oe
        d.s1 = '{cs_n: cs_n, sclk: sclk, din: din};
        d.s2 = q.s1;
        d.pdn1 = power_down_n;
        d.pdn2 = q.pdn1;
        d.sclk_prev = q.s2.sclk;
        d.rx_valid = 1'b0;
        active = port_open(q.s2);
        rise = active && q.s2.sclk && !q.sclk_prev;
        fall = active && !q.s2.sclk && q.sclk_prev;
        // new conversion word: register goes invalid for a short span
        if (conv_valid && q.upd_cnt == 3'h0) begin
            d.upd_cnt = adc_port_pkg::UPDATE_INVALID_OSC;
            d.out_reg = conv_data;
        end else if (q.upd_cnt != 3'h0) begin
            d.upd_cnt = q.upd_cnt - 3'h1;
            if (q.upd_cnt == 3'h1) begin
                d.rdy_n = 1'b0;
            end
        end
        // receive side: sample data in on rising edges
        if (rise) begin
            d.rx_sh = {q.rx_sh[6:0], q.s2.din};
            d.rx_cnt = q.rx_cnt + 3'h1;
            if (q.rx_cnt == 3'h7) begin
                d.rx_byte = {q.rx_sh[6:0], q.s2.din};
                d.rx_valid = 1'b1;
            end
        end
        // release timer counts oscillator periods after any serial edge
        if (rise || fall) begin
            d.idle_cnt = 4'h0;
        end else if (q.idle_cnt != 4'hf) begin
            d.idle_cnt = q.idle_cnt + 4'h1;
        end
        case (q.st)
            adc_port_pkg::ST_IDLE: begin
                d.oe = 1'b0;
                // no load while the word is mid-update
                if (fall && q.upd_cnt == 3'h0) begin
                    d.shift = q.out_reg;
                    d.bit_cnt = 5'h0;
                    d.st = adc_port_pkg::ST_SHIFT;
                end
            end
            adc_port_pkg::ST_SHIFT: begin
                d.oe = 1'b1;
                d.dout = q.shift[23];
                // a word landing on the same edge keeps ready low: set wins
                if (rise && q.upd_cnt != 3'h1) begin
                    d.rdy_n = 1'b1; // read started, ready returns high
                end
                if (fall) begin
                    d.shift = {q.shift[22:0], 1'b0};
                    d.bit_cnt = q.bit_cnt + 5'h1;
                    if (q.bit_cnt == 5'h16) begin
                        d.st = adc_port_pkg::ST_HOLD;
                    end
                end
            end
            adc_port_pkg::ST_HOLD: begin
                d.dout = q.shift[23];
                // release inside the 6..10 window after the last edge
                if (q.idle_cnt == adc_port_pkg::RELEASE_AT_OSC) begin
                    d.oe = 1'b0;
                    d.st = adc_port_pkg::ST_IDLE;
                end
            end
            default: d.st = adc_port_pkg::ST_IDLE;
        endcase
        // synchronised chip select high ends the transfer and clears the byte count
        if (!active) begin
            d.oe = 1'b0;
            d.st = adc_port_pkg::ST_IDLE;
            d.rx_cnt = 3'h0;
        end
    end

    // power-down holds the state at its reset value, but the power-down synchroniser still runs
    // clock history starts at its idle high level, so a select tied
    // low never sees a false rise once reset or power-down ends
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.rdy_n <= 1'b1;
            q.s1.cs_n <= 1'b1;
            q.s2.cs_n <= 1'b1;
            q.s1.sclk <= 1'b1;
            q.s2.sclk <= 1'b1;
            q.sclk_prev <= 1'b1;
        end else if (!q.pdn2) begin
            q <= '0;
            q.rdy_n <= 1'b1;
            q.s1.cs_n <= 1'b1;
            q.s2.cs_n <= 1'b1;
            q.s1.sclk <= 1'b1;
            q.s2.sclk <= 1'b1;
            q.sclk_prev <= 1'b1;
            q.pdn1 <= power_down_n;
            q.pdn2 <= q.pdn1;
        end else begin
            q <= d;
        end
    end

    // oe drop on cs rise is a comb path so release is immediate
    assign dout = q.dout;
    assign dout_oe = q.oe && !cs_n && q.pdn2;
    assign conversion_ready_n = q.rdy_n;
    assign rx_byte = q.rx_byte;
    assign rx_byte_valid = q.rx_valid;

    // shared analog/data pins, bit n with input n
    assign gpio_pin_out = gpio_out;
    assign gpio_pin_oe = gpio_dir & {8{q.pdn2}};
    assign gpio_pin_in = gpio_in;

    // release timing, select gating, power-down, load, ready behaviour and byte pulse
    release_window_a: assert property (@(posedge ref_clk)
        disable iff (!resetn)
        q.st == adc_port_pkg::ST_HOLD &&
        q.idle_cnt < adc_port_pkg::RELEASE_AT_OSC |-> q.oe)
        else $error("output released too early");
    release_late_a: assert property (@(posedge ref_clk)
        disable iff (!resetn)
        q.idle_cnt > adc_port_pkg::RELEASE_AT_OSC && q.pdn2 |->
        !q.oe || q.st == adc_port_pkg::ST_SHIFT)
        else $error("output released too late");
    cs_release_a: assert property (@(posedge ref_clk)
        disable iff (!resetn)
        cs_n |-> !dout_oe)
        else $error("output driven with chip select high");
    pdn_halt_a: assert property (@(posedge ref_clk)
        disable iff (!resetn)
        !q.pdn2 |=> !q.oe && q.rdy_n)
        else $error("logic ran in power-down");
    inactive_a: assert property (@(posedge ref_clk)
        disable iff (!resetn)
        !active |=> q.st == adc_port_pkg::ST_IDLE)
        else $error("transfer while deselected");
    ready_fall_a: assert property (@(posedge ref_clk)
        disable iff (!resetn)
        q.pdn2 && q.upd_cnt == 3'h1 && !conv_valid |=> !q.rdy_n)
        else $error("ready did not fall after update");
    no_load_a: assert property (@(posedge ref_clk)
        disable iff (!resetn)
        q.upd_cnt != 3'h0 && q.st == adc_port_pkg::ST_IDLE |=>
        q.st != adc_port_pkg::ST_SHIFT)
        else $error("read during update");
    edge_gate_a: assert property (@(posedge ref_clk)
        disable iff (!resetn)
        q.s2.cs_n |-> !rise && !fall)
        else $error("edge seen while deselected");
    ready_hold_a: assert property (@(posedge ref_clk)
        disable iff (!resetn)
        !q.rdy_n && q.pdn2 && !(rise && q.st == adc_port_pkg::ST_SHIFT)
        |=> !q.rdy_n)
        else $error("ready rose without a read");
    byte_pulse_a: assert property (@(posedge ref_clk)
        disable iff (!resetn)
        q.rx_valid |=> !q.rx_valid)
        else $error("received byte flagged twice");
    // main scenarios worth seeing at least once
    byte_cov: cover property (@(posedge ref_clk) rx_byte_valid);
    read_cov: cover property (@(posedge ref_clk)
        q.st == adc_port_pkg::ST_HOLD ##1 q.st == adc_port_pkg::ST_IDLE);
    ready_cov: cover property (@(posedge ref_clk) $fell(conversion_ready_n));
    // select held low through a release, as a tied-low host does
    hold_cov: cover property (@(posedge ref_clk)
        q.st == adc_port_pkg::ST_HOLD && !cs_n ##1
        q.st == adc_port_pkg::ST_IDLE && !cs_n);
    pdn_cov: cover property (@(posedge ref_clk)
        resetn && !q.pdn2 && !power_down_n);
endmodule
`default_nettype wire

// file: tb/adc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module adc_host_model (
    input wire logic ref_clk,
    input wire logic dout,
    input wire logic dout_oe,
    output var logic cs_n,
    output var logic sclk,
    output var logic din
);
    logic last_q = 1'b0;
    // released line reads inverted, never as a kept value
    wire logic line = dout_oe ? dout : ~last_q;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
    end
    // falls shift out, rises take din, all under cs_n low
    task automatic xfer(input logic [23:0] tx, input int nf,
        output logic [23:0] rx, output logic oe_end, output logic oe_mid,
        input bit hold_cs);
        rx = 24'h0;
        oe_end = 1'b1;
        oe_mid = 1'b0;
        cs_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        for (int i = 0; i < nf; i++) begin
            sclk = 1'b0;
            din = tx[23 - i];
            repeat (4) @(negedge ref_clk);
            sclk = 1'b1;
            repeat (4) @(negedge ref_clk);
            rx = {rx[22:0], line};
            last_q = line;
        end
        // release window seen from the pin: driven at 6, gone by 10
        if (nf == 24) begin
            repeat (2) @(negedge ref_clk);
            oe_mid = dout_oe;
            repeat (4) @(negedge ref_clk);
            oe_end = dout_oe;
            repeat (10) @(negedge ref_clk);
        end else begin
            oe_mid = dout_oe;
        end
        // a held select keeps the port open for the next word
        if (!hold_cs) cs_n = 1'b1;
        #1;
        if (nf != 24) oe_end = dout_oe;
        // gap covers command spacing and the response turnaround
        repeat (50) @(negedge ref_clk);
    endtask
    // clock edges while deselected must be ignored
    task automatic idle_clocks(input int n);
        repeat (n) begin
            repeat (4) @(negedge ref_clk);
            sclk = ~sclk;
        end
    endtask
endmodule
`default_nettype wire

// file: tb/tb_adc_serial_command_timing.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %0t got %h exp %h", $time, (g), (e)); end end
module tb_adc_serial_command_timing;
    logic ref_clk = 1'b0, resetn = 1'b0, power_down_n = 1'b1;
    logic conv_valid = 1'b0, oe_end, oe_mid;
    logic [23:0] conv_data = 24'h0, rx, w;
    logic [7:0] gpio_in = 8'h0, gpio_out = 8'h0, gpio_dir = 8'h0;
    wire logic cs_n, sclk, din, dout, dout_oe, ready_n, rx_byte_valid;
    wire logic [7:0] pin_out, pin_oe, pin_in, rx_byte;
    int fails = 0, num_checks = 0, seed = 32'h1047ce56, n;
    logic [7:0] exp_q[$];
    always #50 ref_clk = ~ref_clk;
    adc_host_model host (.ref_clk(ref_clk), .dout(dout), .dout_oe(dout_oe),
        .cs_n(cs_n), .sclk(sclk), .din(din));
    adc_serial_port uut (.ref_clk(ref_clk), .resetn(resetn),
        .power_down_n(power_down_n), .cs_n(cs_n), .sclk(sclk), .din(din),
        .dout(dout), .dout_oe(dout_oe), .conversion_ready_n(ready_n),
        .conv_data(conv_data), .conv_valid(conv_valid), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_dir(gpio_dir), .gpio_pin_out(pin_out),
        .gpio_pin_oe(pin_oe), .gpio_pin_in(pin_in), .rx_byte(rx_byte),
        .rx_byte_valid(rx_byte_valid));
    // each received byte retires the oldest note; none noted is a fault
    // looked at mid-cycle, clear of the edge that launches the pulse
    always @(negedge ref_clk) begin
        if (rx_byte_valid === 1'b1) begin
            if (exp_q.size() == 0) `CHK(rx_byte_valid, 1'b0)
            else begin
                `CHK(rx_byte, exp_q[0])
                void'(exp_q.pop_front());
            end
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic pulse(input logic [23:0] d);
        @(negedge ref_clk);
        conv_data = d;
        conv_valid = 1'b1;
        @(negedge ref_clk);
        conv_valid = 1'b0;
        repeat (2) @(negedge ref_clk);
        `CHK(ready_n, 1'b1)
    endtask
    task automatic convert(input logic [23:0] d);
        pulse(d);
        for (n = 0; ready_n !== 1'b0 && n < 20; n++) @(negedge ref_clk);
        if (n == 20) begin
            fails++;
            close_out();
        end
        repeat (10) @(negedge ref_clk);
    endtask
    initial begin
        gpio_in = 8'($random(seed));
        gpio_out = 8'($random(seed));
        gpio_dir = 8'($random(seed));
        repeat (2) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (3) @(negedge ref_clk);
        `CHK(ready_n, 1'b1)
        `CHK({pin_out, pin_oe, pin_in}, {gpio_out, gpio_dir, gpio_in})
        // back-to-back reads of random words, din bytes checked too;
        // the first two keep select low across the gap
        for (int k = 0; k < 3; k++) begin
            w = 24'($random(seed));
            rx = 24'($random(seed));
            convert(w);
            `CHK(ready_n, 1'b0)
            for (int b = 2; b >= 0; b--) exp_q.push_back(rx[8*b +: 8]);
            host.xfer(rx, 24, rx, oe_end, oe_mid, k < 2);
            `CHK(rx, w)
            `CHK(oe_mid, 1'b1)
            `CHK(oe_end, 1'b0)
            `CHK(ready_n, 1'b1)
        end
        host.idle_clocks(8);
        `CHK(dout_oe, 1'b0)
        // power-down holds the port state still
        power_down_n = 1'b0;
        // let the synchroniser see it before the word arrives
        repeat (2) @(negedge ref_clk);
        pulse(24'h5a5a5a);
        repeat (10) @(negedge ref_clk);
        `CHK(ready_n, 1'b1)
        `CHK(pin_oe, 8'h00)
        power_down_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        // chip select raised mid-word releases dout at once
        convert(24'($random(seed)));
        host.xfer(24'h0, 5, rx, oe_end, oe_mid, 1'b0);
        `CHK(oe_mid, 1'b1)
        `CHK(oe_end, 1'b0)
        // the cut word stands for a calibration command: two ready periods
        // pass before the host clocks again, and the newer word must win
        convert(24'($random(seed)));
        w = 24'($random(seed));
        @(negedge ref_clk);
        conv_data = w;
        conv_valid = 1'b1;
        @(negedge ref_clk);
        conv_valid = 1'b0;
        repeat (14) @(negedge ref_clk);
        `CHK(ready_n, 1'b0)
        for (int b = 2; b >= 0; b--) exp_q.push_back(w[8*b +: 8]);
        host.xfer(w, 24, rx, oe_end, oe_mid, 1'b0);
        `CHK(rx, w)
        `CHK(exp_q.size(), 0)
        close_out();
    end
    initial begin
        #3000000;
        fails++;
        close_out();
    end
endmodule
`default_nettype wire
